// *** rtl/btsc_map.svh ***
// constants for the bit-test skip and call execution block
`ifndef BTSC_MAP_SVH
`define BTSC_MAP_SVH
`define PC_W        10
`define PC_LO_W     8
`define PCH_W       2
`define SP_W        4
`define NOP_CYCLES  1
`define CALL_CYCLES 2
`endif

// *** rtl/btsc_pkg.sv ***
// types shared by the bit-test skip and call execution block
package btsc_pkg;
  typedef enum logic [2:0]
  {
    op_none,
    op_skip_if_bit_clear,
    op_skip_if_bit_set,
    op_call_immediate,
    op_call_computed
  } op_e;

  // one decoded instruction as handed over by fetch
  typedef struct packed
  {
    op_e        op;
    logic [2:0] bit_sel;
    logic [7:0] operand;
  } instr_s;

  // one push towards the return stack
  typedef struct packed
  {
    logic       push;
    logic [9:0] ret_addr;
  } push_s;
endpackage

// *** rtl/target_former.sv ***
// forms the 10-bit call target for both call kinds
`include "btsc_map.svh"
module target_former
(
  input  wire logic                 i_computed,
  input  wire logic [7:0]           i_operand,
  input  wire logic [7:0]           i_accumulator,
  input  wire logic [1:0]           i_pc_high_buffer,
  input  wire logic [1:0]           i_table_high_pointer,
  output logic      [`PC_W-1:0]     o_target
);
  // high bits from the buffer or the pointer, low bits from operand or accumulator
  always_comb
  begin
    if (i_computed)
      o_target = {i_table_high_pointer, i_accumulator}; // RQ6
    else
      o_target = {i_pc_high_buffer, i_operand}; // RQ5
  end
endmodule

// *** rtl/bit_test_skip_and_call.sv ***
// execution logic for bit-test skips and subroutine calls
//
// Overview of operation
// (RQ1) skip-if-clear: bit 0 discards next, runs nop
// (RQ2) skip-if-set: bit 1 discards next, runs nop
// (RQ3) bit test one cycle, two when skipping
// (RQ4) calls push pc plus one onto stack
// (RQ5) immediate call: pc = {buffer[1:0], operand}
// (RQ6) computed call: pc = {pointer[1:0], accumulator}
// (RQ7) call two cycles, sp plus one, flags kept
`include "btsc_map.svh"
module bit_test_skip_and_call
#(
  parameter int SP_W = `SP_W
)
(
  input  wire logic                 i_clk,
  input  wire logic                 i_resetn,
  input  wire btsc_pkg::instr_s     i_instr,
  input  wire logic                 i_instr_valid,
  input  wire logic [7:0]           i_reg_data,
  input  wire logic [7:0]           i_accumulator,
  input  wire logic [1:0]           i_pc_high_buffer,
  input  wire logic [1:0]           i_table_high_pointer,
  input  wire logic [`PC_W-1:0]     i_pc,
  output logic                      o_busy,
  output logic                      o_discard_next,
  output logic                      o_pc_load,
  output logic      [`PC_W-1:0]     o_pc_next,
  output btsc_pkg::push_s           o_push,
  output logic      [SP_W-1:0]      o_stack_ptr,
  output logic                      o_flags_write
);
  // elaboration check
  if (SP_W < 1 || SP_W > 8)
  begin : g_bad_sp
    $error("stack pointer width out of range");
  end

  typedef enum logic [1:0]
  {
    st_idle,
    st_nop,
    st_call
  } state_e;

  typedef struct packed
  {
    state_e            state;
    logic              discard;
    logic              pc_load;
    logic [`PC_W-1:0]  pc_next;
    btsc_pkg::push_s   push;
    logic [SP_W-1:0]   sp;
  } state_s;

  state_s cur;
  state_s next_cur;
  logic [`PC_W-1:0] target;
  logic             tested_bit;
  logic             is_call;

  // ---------------------------------------------------------------
  // decode helpers
  // ---------------------------------------------------------------
  // both call kinds share the push and the two-cycle sequence
  function automatic logic call_op(input btsc_pkg::op_e op);
    return (op == btsc_pkg::op_call_immediate) || (op == btsc_pkg::op_call_computed);
  endfunction

  // ---------------------------------------------------------------
  // target address
  // ---------------------------------------------------------------
  target_former u_target
  (
    .i_computed           (i_instr.op == btsc_pkg::op_call_computed),
    .i_operand            (i_instr.operand),
    .i_accumulator        (i_accumulator),
    .i_pc_high_buffer     (i_pc_high_buffer),
    .i_table_high_pointer (i_table_high_pointer),
    .o_target             (target)
  );

  assign tested_bit = i_reg_data[i_instr.bit_sel];
  // read only by the assertions below
  assign is_call    = call_op(i_instr.op);

  // ---------------------------------------------------------------
  // next-state logic
  // ---------------------------------------------------------------
  // new instructions are only taken in idle; fetch holds while busy
  always_comb
  begin
    next_cur          = cur;
    next_cur.discard  = 1'b0;
    next_cur.pc_load  = 1'b0;
    next_cur.push     = '0;
    case (cur.state)
      st_idle:
      begin
        if (i_instr_valid)
        begin
          case (i_instr.op)
            btsc_pkg::op_skip_if_bit_clear:
            begin
              if (!tested_bit) // RQ1
              begin
                next_cur.discard = 1'b1;
                next_cur.state   = st_nop; // RQ3
              end
            end
            btsc_pkg::op_skip_if_bit_set:
            begin
              if (tested_bit) // RQ2
              begin
                next_cur.discard = 1'b1;
                next_cur.state   = st_nop; // RQ3
              end
            end
            btsc_pkg::op_call_immediate,
            btsc_pkg::op_call_computed:
            begin
              next_cur.push.push     = 1'b1;
              next_cur.push.ret_addr = i_pc + 10'h001; // RQ4
              next_cur.sp            = cur.sp + SP_W'(1'b1); // RQ7
              next_cur.pc_next       = target;
              next_cur.state         = st_call;
            end
            default:
            begin
              next_cur.state = st_idle;
            end
          endcase
        end
      end
      st_nop:
      begin
        next_cur.state = st_idle; // RQ3
      end
      st_call:
      begin
        next_cur.pc_load = 1'b1; // RQ7
        next_cur.state   = st_idle;
      end
      default:
      begin
        next_cur.state = st_idle;
      end
    endcase
  end

  // ---------------------------------------------------------------
  // state register
  // ---------------------------------------------------------------
  always_ff @(posedge i_clk)
  begin
    if (!i_resetn)
      cur <= '{state: st_idle, discard: 1'b0, pc_load: 1'b0, pc_next: '0,
               push: '0, sp: '0};
    else
      cur <= next_cur;
  end

  // outputs; busy is decoded from the registered state, so fetch stalls from the cycle after the take
  assign o_busy         = (cur.state != st_idle);
  assign o_discard_next = cur.discard;
  assign o_pc_load      = cur.pc_load;
  assign o_pc_next      = cur.pc_next;
  assign o_push         = cur.push;
  assign o_stack_ptr    = cur.sp;
  assign o_flags_write  = 1'b0; // RQ7

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  a_skip_clear: assert property (@(posedge i_clk) disable iff (!i_resetn) // RQ1
    (!o_busy && i_instr_valid && i_instr.op == btsc_pkg::op_skip_if_bit_clear && !tested_bit)
    |=> o_discard_next)
    else $error("skip on clear bit missed");
  a_skip_set: assert property (@(posedge i_clk) disable iff (!i_resetn) // RQ2
    (!o_busy && i_instr_valid && i_instr.op == btsc_pkg::op_skip_if_bit_set)
    |=> (o_discard_next == $past(tested_bit)))
    else $error("skip on set bit wrong");
  a_skip_two: assert property (@(posedge i_clk) disable iff (!i_resetn) // RQ3
    $rose(o_discard_next) |-> o_busy ##1 !o_busy)
    else $error("skip not two cycles");
  a_push_addr: assert property (@(posedge i_clk) disable iff (!i_resetn) // RQ4
    (!o_busy && i_instr_valid && is_call)
    |=> o_push.push && o_push.ret_addr == $past(i_pc) + 10'h001)
    else $error("bad return address");
  a_call_imm: assert property (@(posedge i_clk) disable iff (!i_resetn) // RQ5
    (!o_busy && i_instr_valid && i_instr.op == btsc_pkg::op_call_immediate)
    |=> ##1 o_pc_load && o_pc_next == {$past(i_pc_high_buffer, 2), $past(i_instr.operand, 2)})
    else $error("bad immediate target");
  a_call_comp: assert property (@(posedge i_clk) disable iff (!i_resetn) // RQ6
    (!o_busy && i_instr_valid && i_instr.op == btsc_pkg::op_call_computed)
    |=> ##1 o_pc_load
        && o_pc_next == {$past(i_table_high_pointer, 2), $past(i_accumulator, 2)})
    else $error("bad computed target");
  a_call_sp: assert property (@(posedge i_clk) disable iff (!i_resetn) // RQ7
    (!o_busy && i_instr_valid && is_call)
    |=> o_busy && o_stack_ptr == $past(o_stack_ptr) + 1'b1 ##1 !o_busy && !o_flags_write)
    else $error("call sp or length wrong");
  a_busy_short: assert property (@(posedge i_clk) disable iff (!i_resetn) // RQ3
    o_busy |=> !o_busy)
    else $error("busy longer than one cycle");

  // a test that does not skip must leave fetch running at full rate
  a_skip_none: assert property (@(posedge i_clk) disable iff (!i_resetn) // RQ3
    (!o_busy && i_instr_valid
     && ((i_instr.op == btsc_pkg::op_skip_if_bit_clear && tested_bit)
      || (i_instr.op == btsc_pkg::op_skip_if_bit_set && !tested_bit)))
    |=> !o_busy && !o_discard_next)
    else $error("no-skip test stalled");
  a_discard_pulse: assert property (@(posedge i_clk) disable iff (!i_resetn) // RQ3
    o_discard_next |=> !o_discard_next)
    else $error("discard longer than one cycle");
  a_nop_quiet: assert property (@(posedge i_clk) disable iff (!i_resetn) // RQ3
    o_discard_next |-> !o_pc_load && !o_push.push)
    else $error("nop cycle touched pc or stack");

  // pulses last one cycle; a call always ends in a load
  a_load_after: assert property (@(posedge i_clk) disable iff (!i_resetn) // RQ7
    o_push.push |=> o_pc_load && !o_push.push)
    else $error("push without target load");
  a_sp_moves: assert property (@(posedge i_clk) disable iff (!i_resetn) // RQ7
    $changed(o_stack_ptr) |-> o_push.push)
    else $error("stack pointer moved without push");
endmodule

// *** sim/fetch_model.sv ***
// fetch path model: the program counter the core presents
module fetch_model
(
  input  wire logic       i_clk,
  input  wire logic       i_resetn,
  input  wire logic       i_taken,
  input  wire logic       i_discard,
  input  wire logic       i_load,
  input  wire logic [9:0] i_target,
  output logic      [9:0] o_pc
);
  timeunit 1ns;
  timeprecision 1ns;
  // a load wins over a step, the call's load lands in the cycle after its busy cycle
  always_ff @(posedge i_clk)
  begin
    if (!i_resetn)
      o_pc <= 10'h000;
    else if (i_load)
      o_pc <= i_target;
    else if (i_taken || i_discard)
      o_pc <= o_pc + 10'h001;
  end
endmodule

// *** sim/testbench.sv ***
// self-checking bench for the bit-test skip and call block
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int sp_bits = 3; // narrow pointer so the wrap is reached
  logic               clk = 1'b0;
  logic               resetn = 1'b0;
  btsc_pkg::instr_s   instr = '0;
  logic               valid = 1'b0;
  logic [7:0]         reg_data = 8'h00;
  logic [7:0]         acc = 8'h00;
  logic [1:0]         pch = 2'h0;
  logic [1:0]         tbh = 2'h0;
  logic [9:0]         pc;
  logic [9:0]         pc_next;
  logic               busy;
  logic               discard;
  logic               pc_load;
  logic               flags_write;
  btsc_pkg::push_s    push;
  logic [sp_bits-1:0] sp;
  logic [sp_bits-1:0] exp_sp = '0;
  logic [15:0]        notes[$];
  logic [15:0]        e;
  logic [31:0]        r;
  int                 n_errors = 0;
  int                 n_compared = 0;
  int                 seed = 32'haa04;

  always #50 clk = ~clk;

  bit_test_skip_and_call #(.SP_W(sp_bits)) bit_test_skip_and_call_i
  (.i_clk(clk), .i_resetn(resetn), .i_instr(instr), .i_instr_valid(valid),
   .i_reg_data(reg_data), .i_accumulator(acc), .i_pc_high_buffer(pch),
   .i_table_high_pointer(tbh), .i_pc(pc), .o_busy(busy), .o_discard_next(discard),
   .o_pc_load(pc_load), .o_pc_next(pc_next), .o_push(push), .o_stack_ptr(sp),
   .o_flags_write(flags_write));

  fetch_model fetch_model_i
  (.i_clk(clk), .i_resetn(resetn), .i_taken(valid && !busy), .i_discard(discard),
   .i_load(pc_load), .i_target(pc_next), .o_pc(pc));

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic give_verdict;
    $display("errors %0d compared %0d", n_errors, n_compared);
    if (n_errors == 0 && n_compared > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  // present one instruction; a held valid during busy must be ignored
  task automatic issue(input btsc_pkg::op_e op);
    int k;
    for (k = 0; k < 4 && busy; k++)
      @(posedge clk) #1;
    if (k == 4)
    begin
      n_errors++;
      give_verdict();
    end
    r = $random(seed);
    instr.op = op;
    instr.bit_sel = r[2:0];
    instr.operand = r[10:3];
    reg_data = r[18:11];
    acc = r[26:19];
    pch = r[28:27];
    tbh = r[30:29];
    valid = 1'b1;
    case (op)
      btsc_pkg::op_skip_if_bit_clear:
        if (!reg_data[instr.bit_sel]) notes.push_back(16'h2000);
      btsc_pkg::op_skip_if_bit_set:
        if (reg_data[instr.bit_sel]) notes.push_back(16'h2000);
      btsc_pkg::op_call_immediate, btsc_pkg::op_call_computed:
      begin
        exp_sp = exp_sp + 1'b1;
        notes.push_back({2'h1, 1'b1, pc + 10'h001, exp_sp});
        notes.push_back({2'h2, 1'b0, (op == btsc_pkg::op_call_computed) ?
          {tbh, acc} : {pch, instr.operand}, 3'h0});
      end
      default: ;
    endcase
    @(posedge clk) #1;
  endtask

  // watcher: every event takes the oldest note; kind 3 marks a stray one
  always @(negedge clk)
  begin
    if (resetn && (discard || push.push || pc_load))
    begin
      e = (notes.size() > 0) ? notes.pop_front() : 16'hffff;
      if (discard)
        check({2'h0, busy, 13'h0000}, e);
      else if (push.push)
        check({2'h1, busy, push.ret_addr, sp}, e);
      else
        check({2'h2, busy | flags_write, pc_next, 3'h0}, e);
    end
  end

  // reset, every kind once, then a random stream with fetch gaps
  initial
  begin
    repeat (16) @(posedge clk);
    #1 resetn = 1'b1;
    for (int i = 0; i < 5; i++)
      issue(btsc_pkg::op_e'(i));
    for (int i = 0; i < 80; i++)
    begin
      r = $random(seed);
      if (r[7])
      begin
        valid = 1'b0;
        @(posedge clk) #1;
      end
      issue(btsc_pkg::op_e'(r[2:0] % 3'h5));
    end
    valid = 1'b0;
    repeat (4) @(posedge clk);
    check(16'(notes.size()), 16'h0000);
    give_verdict();
  end
endmodule
